// file: inc/isst_params.svh
// Purpose: Constants for the input signature self test
// Assumes: Byte wide register port, 14-bit sample bus
// Notes:   Offsets are register indices
`ifndef ISST_PARAMS_SVH
`define ISST_PARAMS_SVH

`define ISST_ADDR_CTRL      8'h11
`define ISST_ADDR_SIG_LOW   8'h12
`define ISST_ADDR_SIG_MLOW  8'h13
`define ISST_ADDR_SIG_MHIGH 8'h14
`define ISST_ADDR_SIG_HIGH  8'h15

`define ISST_BIT_CLEAR      0
`define ISST_BIT_POST_EN    1
`define ISST_BIT_RX_EN      2
`define ISST_BIT_READOUT    5
`define ISST_SEL_HI         7
`define ISST_SEL_LO         6

`define ISST_CTRL_RESET     8'h00
`define ISST_SIG_RESET      32'h0000_0000
`define ISST_SAMPLE_W       14
`define ISST_SIG_W          32
`define ISST_FIFO_AW        3

`endif

// file: inc/isst_pkg.sv
// Purpose: Types and signature step for the input signature self test
// Assumes: isst_params.svh supplies widths
// Notes:   Bit k of the update equation is index k-1 here
`include "isst_params.svh"

package isst_pkg;

  typedef logic [`ISST_SAMPLE_W-1:0] isst_sample_t;
  typedef logic [`ISST_SIG_W-1:0]    isst_sig_t;

  typedef enum logic [1:0] {
    ISST_SEL_RX_P1,
    ISST_SEL_RX_P2,
    ISST_SEL_POST_P1,
    ISST_SEL_POST_P2
  } isst_sel_t;

  // One rising and one falling sample of the bus
  typedef struct packed {
    isst_sample_t p1;
    isst_sample_t p2;
  } isst_pair_t;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } isst_req_t;

  function automatic isst_sig_t isst_sig_step(input isst_sig_t s, input isst_sample_t d);
    isst_sig_t n;
    n = s;
    if (d != '0)
    begin
      n[0] = s[31] ^ d[0];
      n[1] = s[0] ^ d[1];
      for (int i = 2; i < `ISST_SAMPLE_W; i++)
        n[i] = ~(s[i-1] ^ d[i]);
      for (int i = `ISST_SAMPLE_W; i < `ISST_SIG_W; i++)
        n[i] = s[i-1];
    end
    return n;
  endfunction : isst_sig_step

endpackage : isst_pkg

// file: rtl/isst_top.sv
// Purpose: Signature self test on the double data rate sample input
// Assumes: i_mclk is the converter clock, i_dclk the input data clock
// Notes:   Receiver stage on i_dclk, post-FIFO stage on i_mclk
`timescale 1ns/1ns
`include "isst_params.svh"

module isst_top (
  // Converter clock domain
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst,
  // Link: input data clock and sample bus
  input  wire logic                 i_dclk,
  input  wire isst_pkg::isst_sample_t i_sample_bus,
  // Register port and converter sample output
  input  wire isst_pkg::isst_req_t  i_req,
  output logic [7:0]                o_reg_rdata,
  output isst_pkg::isst_sample_t    o_sample_out
);
  import isst_pkg::*;

  localparam int DEPTH = 1 << `ISST_FIFO_AW;

  // Link domain reset: asserts at once, releases on i_dclk
  // Without it the receiver could leave reset in the middle of a pair
  logic [1:0] drst_sync_r;
  logic       drst;

  always_ff @(posedge i_dclk or posedge i_rst)
  begin
    if (i_rst)
      drst_sync_r <= 2'b11;
    else
      drst_sync_r <= {drst_sync_r[0], 1'b0};
  end
  assign drst = drst_sync_r[1];

  // Control register, converter domain
  // Clear and receiver enable act in the link domain two link clocks later
  logic [7:0] ctrl_r;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      ctrl_r <= `ISST_CTRL_RESET;
    else if (i_req.wr && i_req.addr == `ISST_ADDR_CTRL)
      ctrl_r <= i_req.wdata;
  end

  // Clear and receiver enable into the link domain
  // Single bits, so a plain two-flop synchroniser is enough
  logic [1:0] clr_sync_r;
  logic [1:0] rxen_sync_r;

  always_ff @(posedge i_dclk or posedge drst)
  begin
    if (drst)
    begin
      clr_sync_r  <= 2'b00;
      rxen_sync_r <= 2'b00;
    end
    else
    begin
      clr_sync_r  <= {clr_sync_r[0], ctrl_r[`ISST_BIT_CLEAR]};
      rxen_sync_r <= {rxen_sync_r[0], ctrl_r[`ISST_BIT_RX_EN]};
    end
  end

  // Falling-edge lane capture
  // Phase 2 lane: the second word of each pair
  isst_sample_t fall_r;

  always_ff @(negedge i_dclk or posedge drst)
  begin
    if (drst)
      fall_r <= '0;
    else
      fall_r <= i_sample_bus;
  end

  // Rising-edge lane capture; the pair completes at the next rising edge
  // The first pair after reset is the all-zero startup pair and steps nothing
  isst_sample_t rise_r;
  logic         pair_vld_r;

  always_ff @(posedge i_dclk or posedge drst)
  begin
    if (drst)
    begin
      rise_r     <= '0;
      pair_vld_r <= 1'b0;
    end
    else
    begin
      rise_r     <= i_sample_bus;
      pair_vld_r <= 1'b1;
    end
  end

  // Receiver-stage generators, one per lane
  isst_sig_t rx_sig_r [2];
  isst_sample_t rx_lane [2];
  assign rx_lane[0] = rise_r;
  assign rx_lane[1] = fall_r;

  for (genvar g = 0; g < 2; g++)
  begin : g_rx
    always_ff @(posedge i_dclk or posedge drst)
    begin
      if (drst)
        rx_sig_r[g] <= `ISST_SIG_RESET;
      else if (clr_sync_r[1])
        rx_sig_r[g] <= `ISST_SIG_RESET;
      else if (rxen_sync_r[1] && pair_vld_r)
        rx_sig_r[g] <= isst_sig_step(rx_sig_r[g], rx_lane[g]);
    end
  end

  // Receiver signatures to converter domain by toggle handshake
  // Ack toggles back from the converter side; a new snapshot waits for it
  isst_sig_t  rx_snap_r [2];
  logic       snap_req_r;
  logic       snap_ack_r;
  logic [1:0] ack_sync_r;

  always_ff @(posedge i_dclk or posedge drst)
  begin
    if (drst)
    begin
      snap_req_r  <= 1'b0;
      rx_snap_r[0] <= `ISST_SIG_RESET;
      rx_snap_r[1] <= `ISST_SIG_RESET;
      ack_sync_r  <= 2'b00;
    end
    else
    begin
      ack_sync_r <= {ack_sync_r[0], snap_ack_r};
      // Snapshot only while the previous one has been taken
      if (ack_sync_r[1] == snap_req_r)
      begin
        rx_snap_r[0] <= rx_sig_r[0];
        rx_snap_r[1] <= rx_sig_r[1];
        snap_req_r   <= ~snap_req_r;
      end
    end
  end

  // Copy taken in the converter domain while the snapshot holds still
  logic [1:0] req_sync_r;
  isst_sig_t  rx_copy_r [2];

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      snap_ack_r   <= 1'b0;
      req_sync_r   <= 2'b00;
      rx_copy_r[0] <= `ISST_SIG_RESET;
      rx_copy_r[1] <= `ISST_SIG_RESET;
    end
    else
    begin
      req_sync_r <= {req_sync_r[0], snap_req_r};
      if (req_sync_r[1] != snap_ack_r)
      begin
        rx_copy_r[0] <= rx_snap_r[0];
        rx_copy_r[1] <= rx_snap_r[1];
        snap_ack_r   <= req_sync_r[1];
      end
    end
  end

  // Clock-crossing FIFO of sample pairs, gray pointers
  // Only the pointers cross, each in gray code behind two flops
  isst_pair_t                fifo_mem [DEPTH];
  logic [`ISST_FIFO_AW:0]    wptr_bin_r;
  logic [`ISST_FIFO_AW:0]    wptr_gray_r;
  logic [`ISST_FIFO_AW:0]    rptr_bin_r;
  logic [`ISST_FIFO_AW:0]    rptr_gray_r;
  logic [`ISST_FIFO_AW:0]    rptr_w1_r;
  logic [`ISST_FIFO_AW:0]    rptr_w2_r;
  logic [`ISST_FIFO_AW:0]    wptr_r1_r;
  logic [`ISST_FIFO_AW:0]    wptr_r2_r;
  logic [`ISST_FIFO_AW:0]    wptr_nxt;
  logic [`ISST_FIFO_AW:0]    rptr_nxt;
  logic                      fifo_full;
  logic                      fifo_empty;

  assign wptr_nxt   = wptr_bin_r + 1'b1;
  assign rptr_nxt   = rptr_bin_r + 1'b1;
  // Full against the synchronised read pointer in gray form
  assign fifo_full  = (wptr_gray_r == {~rptr_w2_r[`ISST_FIFO_AW:`ISST_FIFO_AW-1],
                                       rptr_w2_r[`ISST_FIFO_AW-2:0]});
  assign fifo_empty = (rptr_gray_r == wptr_r2_r);

  always_ff @(posedge i_dclk)
  begin
    if (pair_vld_r && !fifo_full)
      fifo_mem[wptr_bin_r[`ISST_FIFO_AW-1:0]] <= '{p1: rise_r, p2: fall_r};
  end

  always_ff @(posedge i_dclk or posedge drst)
  begin
    if (drst)
    begin
      wptr_bin_r  <= '0;
      wptr_gray_r <= '0;
      rptr_w1_r   <= '0;
      rptr_w2_r   <= '0;
    end
    else
    begin
      rptr_w1_r <= rptr_gray_r;
      rptr_w2_r <= rptr_w1_r;
      // A pair is dropped on overflow; the converter clock is faster
      if (pair_vld_r && !fifo_full)
      begin
        wptr_bin_r  <= wptr_nxt;
        wptr_gray_r <= wptr_nxt ^ (wptr_nxt >> 1);
      end
    end
  end

  isst_pair_t rd_pair_r;
  logic       rd_vld_r;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rptr_bin_r  <= '0;
      rptr_gray_r <= '0;
      wptr_r1_r   <= '0;
      wptr_r2_r   <= '0;
      rd_pair_r   <= '0;
      rd_vld_r    <= 1'b0;
    end
    else
    begin
      wptr_r1_r <= wptr_gray_r;
      wptr_r2_r <= wptr_r1_r;
      rd_vld_r  <= !fifo_empty;
      if (!fifo_empty)
      begin
        rd_pair_r   <= fifo_mem[rptr_bin_r[`ISST_FIFO_AW-1:0]];
        rptr_bin_r  <= rptr_nxt;
        rptr_gray_r <= rptr_nxt ^ (rptr_nxt >> 1);
      end
    end
  end

  // Post-FIFO generators see the same lane words as the receiver
  // Valid for 1x mode only: each entry is one pair, so both stages see
  // the same words in the same order and end on the same signature
  isst_sig_t    post_sig_r [2];
  isst_sample_t post_lane [2];
  assign post_lane[0] = rd_pair_r.p1;
  assign post_lane[1] = rd_pair_r.p2;

  for (genvar g = 0; g < 2; g++)
  begin : g_post
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
      if (i_rst)
        post_sig_r[g] <= `ISST_SIG_RESET;
      else if (ctrl_r[`ISST_BIT_CLEAR])
        post_sig_r[g] <= `ISST_SIG_RESET;
      else if (ctrl_r[`ISST_BIT_POST_EN] && rd_vld_r)
        post_sig_r[g] <= isst_sig_step(post_sig_r[g], post_lane[g]);
    end
  end

  // Converter data path: first word of each pair read from the FIFO, held between reads; idle passes as is
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      o_sample_out <= '0;
    else if (rd_vld_r)
      o_sample_out <= rd_pair_r.p1;
  end

  // Readback selection
  // Receiver values come from the snapshot copy and trail by a few link cycles
  isst_sig_t sel_sig;

  always_comb
  begin
    case (isst_sel_t'(ctrl_r[`ISST_SEL_HI:`ISST_SEL_LO]))
      ISST_SEL_RX_P1:   sel_sig = rx_copy_r[0];
      ISST_SEL_RX_P2:   sel_sig = rx_copy_r[1];
      ISST_SEL_POST_P1: sel_sig = post_sig_r[0];
      ISST_SEL_POST_P2: sel_sig = post_sig_r[1];
      default:          sel_sig = `ISST_SIG_RESET;
    endcase
  end

  // Signature bytes are read-only; they show zero unless readout is on
  // Limitation: bytes are read one at a time, so a moving signature can tear;
  // hold the idle word on the bus before reading
  logic [7:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = 8'h00;
    case (i_req.addr)
      `ISST_ADDR_CTRL:      rdata_nxt = ctrl_r;
      `ISST_ADDR_SIG_LOW:   rdata_nxt = sel_sig[7:0];
      `ISST_ADDR_SIG_MLOW:  rdata_nxt = sel_sig[15:8];
      `ISST_ADDR_SIG_MHIGH: rdata_nxt = sel_sig[23:16];
      `ISST_ADDR_SIG_HIGH:  rdata_nxt = sel_sig[31:24];
      default:              rdata_nxt = 8'h00;
    endcase
    if (i_req.addr != `ISST_ADDR_CTRL && !ctrl_r[`ISST_BIT_READOUT])
      rdata_nxt = 8'h00;
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      o_reg_rdata <= 8'h00;
    else
      o_reg_rdata <= rdata_nxt;
  end

endmodule : isst_top

// file: testbench/isst_top_asserts.sv
// Purpose: Port assertions for isst_top
// Assumes: Idle sample word is zero
// Notes:   Quiet counters saturate at 63
`timescale 1ns/1ns
module isst_chk (
  // Clock and reset
  input wire logic                   i_mclk,
  input wire logic                   i_rst,
  // Watched ports
  input wire isst_pkg::isst_sample_t i_sample_bus,
  input wire isst_pkg::isst_req_t    i_req,
  input wire logic [7:0]             o_reg_rdata,
  input wire isst_pkg::isst_sample_t o_sample_out
);
  import isst_pkg::*;
  localparam int Q = 40;
  logic [7:0] ctl_r;
  logic [5:0] wq_r, hq_r, iq_r;
  logic       cw, sr, nz;
  assign cw = i_req.wr && i_req.addr == 8'h11;
  assign sr = i_req.addr inside {[8'h12:8'h15]};
  assign nz = i_sample_bus != '0;
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
      ctl_r <= 8'h00;
    else if (cw)
      ctl_r <= i_req.wdata;
  // Cycles since a write, a write or an enabled nonzero word, any nonzero word
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
    begin
      wq_r <= '0;
      hq_r <= '0;
      iq_r <= '0;
    end
    else
    begin
      wq_r <= i_req.wr ? '0 : wq_r + 6'(wq_r != '1);
      hq_r <= i_req.wr || nz && ctl_r[2:1] != 2'b00 ? '0 : hq_r + 6'(hq_r != '1);
      iq_r <= nz ? '0 : iq_r + 6'(iq_r != '1);
    end
  sequence cw_s;
    cw;
  endsequence
  sequence cr_s;
    !i_req.wr && i_req.addr == 8'h11;
  endsequence
  default clocking dc @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  ctl_echo_a: assert property (cw_s ##1 cr_s |=> o_reg_rdata == $past(i_req.wdata, 2))
    else $error("control echo wrong");
  ctl_keep_a: assert property (cr_s |=> o_reg_rdata == $past(ctl_r))
    else $error("control value wrong");
  unmapped_zero_a: assert property (!(i_req.addr inside {[8'h11:8'h15]}) |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  read_gate_a: assert property (sr && !ctl_r[5] |=> o_reg_rdata == 8'h00)
    else $error("gated byte not zero");
  sig_hold_a: assert property (hq_r >= Q && $stable(i_req.addr) |=> $stable(o_reg_rdata))
    else $error("signature moved while quiet");
  clear_zero_a: assert property (ctl_r[0] && wq_r >= Q && sr |=> o_reg_rdata == 8'h00)
    else $error("cleared byte not zero");
  tap_idle_a: assert property (iq_r >= Q |-> o_sample_out == '0)
    else $error("tap not idle");
  ro_bytes_a: assert property ((i_req.wr && sr && wq_r >= Q && iq_r >= Q) ##1
    (!i_req.wr && $stable(i_req.addr)) |=> $stable(o_reg_rdata))
    else $error("byte changed by write");
endmodule : isst_chk

bind isst_top isst_chk i_chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_sample_bus(i_sample_bus),
  .i_req(i_req), .o_reg_rdata(o_reg_rdata), .o_sample_out(o_sample_out));

// file: testbench/isst_src.sv
// Purpose: Sample source model driving the link
// Assumes: Bench queues whole pairs
// Notes:   Clock runs free, reset and clear need it
`timescale 1ns/1ns
module isst_src (
  // Link
  output logic                   o_dclk,
  output isst_pkg::isst_sample_t o_data
);
  import isst_pkg::*;
  isst_pair_t q[$];
  isst_pair_t p;
  initial
  begin
    o_dclk = 1'b0;
    o_data = '0;
    #17;
    forever
    begin
      p = q.size() > 0 ? q.pop_front() : '0;
      #31 o_data = p.p1;
      #31 o_dclk = 1'b1;
      #31 o_data = p.p2;
      #32 o_dclk = 1'b0;
    end
  end
endmodule : isst_src

// file: testbench/testbench.sv
// Purpose: Self-checking bench for isst_top
// Assumes: Signed idle word 0x0000, 1x mode
// Notes:   Expected signatures from a local model
`timescale 1ns/1ns
module testbench;
  import isst_pkg::*;
  logic         i_mclk;
  logic         i_rst;
  logic         dclk;
  isst_sample_t dat;
  isst_sample_t tap;
  isst_req_t    req;
  logic [7:0]   rd;
  logic [31:0]  e [2];
  isst_pair_t   p;
  int           bad_count;
  int           tests_run;
  isst_top i_isst_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_dclk(dclk), .i_sample_bus(dat),
                       .i_req(req), .o_reg_rdata(rd), .o_sample_out(tap));
  isst_src i_isst_src (.o_dclk(dclk), .o_data(dat));
  function automatic logic [31:0] step(logic [31:0] s, logic [13:0] d);
    logic [31:0] n;
    n = {s[30:0], s[31]};
    n[13:0] = n[13:0] ^ d ^ 14'h3ffc;
    return d == 14'h0000 ? s : n;
  endfunction : step
  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge i_mclk);
    req = '{1'b1, a, d};
    @(negedge i_mclk);
    req.wr = 1'b0;
  endtask : wr
  task automatic cmp(logic [31:0] g, logic [31:0] x);
    tests_run++;
    if (g !== x)
    begin
      bad_count++;
      $display("unexpected at %0t got %h expected %h", $time, g, x);
    end
  endtask : cmp
  task automatic chk(logic [7:0] a, logic [7:0] x);
    @(negedge i_mclk);
    req.addr = a;
    @(negedge i_mclk);
    cmp({24'h0, rd}, {24'h0, x});
  endtask : chk
  task automatic chk32(logic [7:0] c, logic [31:0] x);
    wr(8'h11, c);
    for (int i = 3; i >= 0; i--)
      chk(8'(8'h12 + i), x[8*i +: 8]);
  endtask : chk32
  // Zero word in the stream must not step the signature
  task automatic send(int n, bit upd);
    for (int i = 0; i < n; i++)
    begin
      p.p1 = i == 0 ? 14'h3fff : 14'($urandom);
      p.p2 = i == 1 ? 14'h0000 : 14'($urandom);
      if (upd)
      begin
        e[0] = step(e[0], p.p1);
        e[1] = step(e[1], p.p2);
      end
      i_isst_src.q.push_back(p);
    end
    for (int k = 0; k < 3000 && i_isst_src.q.size() > 0; k++)
      @(negedge i_mclk);
    cmp(32'(i_isst_src.q.size()), 32'h0);
    repeat (100) @(negedge i_mclk);
    cmp({18'h0, tap}, 32'h0);
  endtask : send
  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  initial
  begin
    #200000;
    bad_count++;
    complete_run();
  end
  initial
  begin
    void'($urandom(32'hff76));
    req = '0;
    i_rst = 1'b1;
    bad_count = 0;
    tests_run = 0;
    repeat (12) @(negedge i_mclk);
    i_rst = 1'b0;
    wr(8'h11, 8'hc6);
    chk(8'h11, 8'hc6);
    // Two full reset pulses with the link clock running and the bus idle
    for (int k = 0; k < 2; k++)
    begin
      repeat (52) @(negedge i_mclk);
      i_rst = 1'b1;
      repeat (52) @(negedge i_mclk);
      i_rst = 1'b0;
    end
    repeat (50) @(negedge i_mclk);
    chk(8'h11, 8'h00);
    chk(8'h40, 8'h00);
    for (int r = 0; r < 2; r++)
    begin
      wr(8'h11, 8'h27);
      repeat (160) @(negedge i_mclk);
      chk(8'h13, 8'h00);
      wr(8'h11, 8'h06);
      for (int s = 0; s < 4; s++)
        chk32(8'(8'h26 + 64 * s), 32'h0);
      e = '{32'h0, 32'h0};
      send(8 + 8 * r, 1'b1);
      for (int s = 0; s < 4; s++)
        chk32(8'(8'h26 + 64 * s), e[s % 2]);
    end
    wr(8'h11, 8'h00);
    chk(8'h15, 8'h00);
    // Let the enables settle in the link domain first
    repeat (20) @(negedge i_mclk);
    send(6, 1'b0);
    chk32(8'h20, e[0]);
    chk32(8'ha0, e[0]);
    repeat (50) @(negedge i_mclk);
    wr(8'h12, 8'h5a);
    chk(8'h12, e[0][7:0]);
    complete_run();
  end
endmodule : testbench
